// ### bench/sfc_asserts.sv
// concurrent checks on the secure state fault checks ports
`timescale 1ns/1ps
module sfc_asserts #(
	parameter int CNT_W = 8
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// gateway and fetch
	input wire logic secure_gateway_instr,
	input wire logic thread_mode,
	input wire logic exc_frame_present,
	input wire logic gateway_commit,
	input wire logic invalid_entry_fault,
	input wire logic fetch_valid,
	input wire logic fetch_priv_exec_never,
	input wire logic privileged,
	input wire logic memory_management_fault,
	// preemption and fp
	input wire logic ns_exc_req,
	input wire logic ns_exc_nmi_class,
	input wire logic secure_context,
	input wire logic in_severe_fault_handler,
	input wire logic ns_preempt_grant,
	input wire logic ns_state,
	input wire logic fp_owner_secure,
	input wire logic exception_return_code,
	input wire logic return_from_secure,
	input wire logic fp_ns_view_block,
	input wire logic fp_context_clear
);
	logic [4:0] ctrl_r;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of the control register from apb writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctrl_r <= 5'h00;
		else if (psel && penable && pwrite && paddr == 12'h000) ctrl_r <= pwdata[4:0];
	end
	a_no_block_clean: assert property (
		secure_gateway_instr && !ctrl_r[0] |=> !invalid_entry_fault)
		else $error("gateway faulted with reentry block off");
	a_reentry_fault: assert property (
		secure_gateway_instr && thread_mode && exc_frame_present
		&& ctrl_r[0] |=> invalid_entry_fault && !gateway_commit)
		else $error("reentry not faulted or committed");
	a_fault_cause: assert property (
		invalid_entry_fault |-> $past(secure_gateway_instr && thread_mode && exc_frame_present))
		else $error("entry fault without reentry");
	a_handler_free: assert property (
		secure_gateway_instr && !thread_mode |=> !invalid_entry_fault && gateway_commit)
		else $error("handler gateway faulted");
	a_exec_never_fault: assert property (
		fetch_valid && fetch_priv_exec_never && privileged |=> memory_management_fault)
		else $error("exec never fetch not faulted");
	a_exec_never_cause: assert property (
		memory_management_fault |-> $past(fetch_valid && fetch_priv_exec_never && privileged))
		else $error("exec never fault without cause");
	a_nmi_preempt: assert property (
		ns_exc_req && ns_exc_nmi_class && ctrl_r[1]
		&& !in_severe_fault_handler |-> ns_preempt_grant)
		else $error("nmi class preempt refused");
	a_severe_kept: assert property (
		ns_exc_req && secure_context && in_severe_fault_handler |-> !ns_preempt_grant)
		else $error("severe handler preempted");
	a_fp_hidden: assert property (
		ctrl_r[2] && fp_owner_secure && ns_state |-> fp_ns_view_block)
		else $error("secure fp view open");
	a_fp_cleared: assert property (
		exception_return_code && (ctrl_r[3] || ctrl_r[4] && return_from_secure) |=> fp_context_clear)
		else $error("fp context not cleared");
	a_fp_clear_cause: assert property (
		fp_context_clear |-> $past(exception_return_code))
		else $error("fp clear without return");
endmodule : sfc_asserts

// ### bench/tb_top.sv
// testbench for the secure state fault checks block
`timescale 1ns/1ps
module tb_top;
	import sfc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd_v;
	logic pready, pslverr, err_v, gateway_commit, invalid_entry_fault, memory_management_fault;
	logic ns_preempt_grant, fp_ns_view_block, fp_context_clear, irq;
	logic secure_gateway_instr = 0, thread_mode = 0, exc_frame_present = 0;
	logic fetch_valid = 0, fetch_priv_exec_never = 0, privileged = 0, ns_exc_req = 0;
	logic ns_exc_nmi_class = 0, secure_context = 0, in_severe_fault_handler = 0;
	logic ns_state = 0, fp_owner_secure = 0, exception_return_code = 0, return_from_secure = 0;
	logic [11:0] offs [4] = '{SFC_OFS_CTRL, SFC_OFS_INT_STATUS, SFC_OFS_INT_MASK, SFC_OFS_FAULT_COUNT};
	int failures = 0, n_checks = 0, cyc = 0;
	always #50 pclk = ~pclk;
	sfc_secure_checks u_sfc_secure_checks (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .secure_gateway_instr, .thread_mode,
		.exc_frame_present, .gateway_commit, .invalid_entry_fault, .fetch_valid,
		.fetch_priv_exec_never, .privileged, .memory_management_fault, .ns_exc_req,
		.ns_exc_nmi_class, .secure_context, .in_severe_fault_handler, .ns_preempt_grant,
		.ns_state, .fp_owner_secure, .exception_return_code, .return_from_secure, .fp_ns_view_block,
		.fp_context_clear, .irq);
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// one gateway instruction, then its outcome
	task automatic gw(input logic t, input logic f, input logic e);
		@(posedge pclk);
		secure_gateway_instr <= 1'b1;
		thread_mode <= t;
		exc_frame_present <= f;
		@(posedge pclk);
		secure_gateway_instr <= 1'b0;
		#1;
		chk("entry fault", 32'(e), 32'(invalid_entry_fault));
		chk("commit", 32'(!e), 32'(gateway_commit));
	endtask : gw
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (offs[i]) begin
			xfer(0, offs[i], 0);
			chk("reset value", 0, rd_v);
		end
		xfer(0, 12'h0f0, 0);
		chk("unmapped error", 1, 32'(err_v));
		$display("test registers done");
		gw(1, 1, 0);
		xfer(1, SFC_OFS_CTRL, 32'h1);
		gw(1, 1, 1);
		chk("masked irq", 0, 32'(irq));
		gw(0, 1, 0);
		gw(1, 0, 0);
		xfer(1, SFC_OFS_INT_MASK, 32'h1);
		#1 chk("irq", 1, 32'(irq));
		xfer(0, SFC_OFS_FAULT_COUNT, 0);
		chk("entry count", 1, rd_v);
		xfer(1, SFC_OFS_INT_STATUS, 32'h1);
		#1 chk("cleared irq", 0, 32'(irq));
		$display("test gateway done");
		@(posedge pclk);
		{fetch_valid, fetch_priv_exec_never, privileged} <= 3'b111;
		@(posedge pclk);
		privileged <= 1'b0;
		#1 chk("mm fault", 1, 32'(memory_management_fault));
		@(posedge pclk);
		#1 chk("unpriv fetch", 0, 32'(memory_management_fault));
		$display("test fetch done");
		@(posedge pclk);
		{ns_exc_req, ns_exc_nmi_class, secure_context} <= 3'b111;
		#1 chk("grant unrouted", 0, 32'(ns_preempt_grant));
		xfer(1, SFC_OFS_CTRL, 32'h2);
		#1 chk("grant routed", 1, 32'(ns_preempt_grant));
		@(posedge pclk);
		in_severe_fault_handler <= 1'b1;
		#1 chk("grant severe", 0, 32'(ns_preempt_grant));
		$display("test preempt done");
		xfer(1, SFC_OFS_CTRL, 32'hc);
		{ns_state, fp_owner_secure, exception_return_code} <= 3'b111;
		#1 chk("fp view block", 1, 32'(fp_ns_view_block));
		@(posedge pclk);
		{ns_state, exception_return_code} <= 2'b00;
		#1 chk("fp clear", 1, 32'(fp_context_clear));
		chk("fp view open", 0, 32'(fp_ns_view_block));
		xfer(1, SFC_OFS_CTRL, 32'h10);
		exception_return_code <= 1'b1;
		@(posedge pclk);
		return_from_secure <= 1'b1;
		#1 chk("fp kept ns return", 0, 32'(fp_context_clear));
		@(posedge pclk);
		{exception_return_code, return_from_secure} <= 2'b00;
		#1 chk("fp clear secure return", 1, 32'(fp_context_clear));
		$display("test fp done");
		xfer(0, SFC_OFS_INT_STATUS, 0);
		chk("event status", 32'he, rd_v);
		xfer(0, SFC_OFS_FAULT_COUNT, 0);
		chk("fault counts", 32'h101, rd_v);
		xfer(0, SFC_OFS_STATE, 0);
		chk("state", 32'h20, rd_v);
		$display("test status done");
		results();
	end
endmodule : tb_top
bind sfc_secure_checks sfc_asserts #(.CNT_W(CNT_W)) u_sfc_asserts (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .secure_gateway_instr, .thread_mode,
	.exc_frame_present, .gateway_commit, .invalid_entry_fault, .fetch_valid,
	.fetch_priv_exec_never, .privileged, .memory_management_fault, .ns_exc_req,
	.ns_exc_nmi_class, .secure_context, .in_severe_fault_handler, .ns_preempt_grant,
	.ns_state, .fp_owner_secure, .exception_return_code, .return_from_secure, .fp_ns_view_block,
	.fp_context_clear);

// ### hdl/sfc_pkg.sv
// constants for the secure state fault checks block
package sfc_pkg;

	// apb register byte offsets
	localparam logic [11:0] SFC_OFS_CTRL = 12'h000;
	localparam logic [11:0] SFC_OFS_STATE = 12'h004;
	localparam logic [11:0] SFC_OFS_INT_STATUS = 12'h008;
	localparam logic [11:0] SFC_OFS_INT_MASK = 12'h00c;
	localparam logic [11:0] SFC_OFS_FAULT_COUNT = 12'h010;

	// control register field positions
	localparam int SFC_CTRL_THREAD_REENTRY_BLOCK = 0;
	localparam int SFC_CTRL_FAULT_NMI_TO_NONSECURE = 1;
	localparam int SFC_CTRL_FP_CONTEXT_SECURE = 2;
	localparam int SFC_CTRL_FP_CLEAR_ON_RETURN = 3;
	localparam int SFC_CTRL_FP_CLEAR_ON_RETURN_LOCK = 4;
	localparam int SFC_CTRL_W = 5;

	// interrupt status and mask field positions
	localparam int SFC_EV_INVALID_ENTRY = 0;
	localparam int SFC_EV_MEM_MANAGE = 1;
	localparam int SFC_EV_NS_PREEMPT = 2;
	localparam int SFC_EV_FP_CLEAR = 3;
	localparam int SFC_EV_W = 4;

	// state register field positions
	localparam int SFC_ST_GATEWAY_BLOCKED = 0;
	localparam int SFC_ST_FP_VIEW_BLOCKED = 1;
	localparam int SFC_ST_PREEMPT_OPEN = 2;
	localparam int SFC_ST_LAST_FAULT_LO = 4;
	localparam int SFC_ST_LAST_FAULT_HI = 5;

	// fault counter field positions
	localparam int SFC_CNT_ENTRY_LO = 0;
	localparam int SFC_CNT_MM_LO = 8;

	// reset values
	localparam logic [SFC_CTRL_W-1:0] SFC_CTRL_RST = 5'h00;
	localparam logic [SFC_EV_W-1:0] SFC_EV_RST = 4'h0;
	localparam logic [7:0] SFC_CNT_RST = 8'h00;

	// register select codes
	typedef enum logic [2:0] {
		SFC_SEL_NONE,
		SFC_SEL_CTRL,
		SFC_SEL_STATE,
		SFC_SEL_INT_STATUS,
		SFC_SEL_INT_MASK,
		SFC_SEL_FAULT_COUNT
	} sfc_sel_e;

	// last fault kind kept in the state register
	typedef enum logic [1:0] {
		SFC_LAST_NONE,
		SFC_LAST_INVALID_ENTRY,
		SFC_LAST_MEM_MANAGE
	} sfc_last_e;

endpackage : sfc_pkg

// ### hdl/sfc_secure_checks.sv
// secure state fault checks: gateway reentry, exec-never, preemption, fp context
`timescale 1ns/1ps

module sfc_secure_checks
	import sfc_pkg::*;
#(
	parameter int CNT_W = 8
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// secure gateway entry
	input wire logic secure_gateway_instr,
	input wire logic thread_mode,
	input wire logic exc_frame_present,
	output logic gateway_commit,
	output logic invalid_entry_fault,
	// instruction fetch permission
	input wire logic fetch_valid,
	input wire logic fetch_priv_exec_never,
	input wire logic privileged,
	output logic memory_management_fault,
	// nonsecure exception preemption
	input wire logic ns_exc_req,
	input wire logic ns_exc_nmi_class,
	input wire logic secure_context,
	input wire logic in_severe_fault_handler,
	output logic ns_preempt_grant,
	// floating point context
	input wire logic ns_state,
	input wire logic fp_owner_secure,
	input wire logic exception_return_code,
	input wire logic return_from_secure,
	output logic fp_ns_view_block,
	output logic fp_context_clear,
	// interrupt
	output logic irq
);

	// register state
	logic [SFC_CTRL_W-1:0] ctrl_r;
	logic [SFC_EV_W-1:0] int_status_r;
	logic [SFC_EV_W-1:0] int_mask_r;
	logic [CNT_W-1:0] entry_cnt_r;
	logic [CNT_W-1:0] mm_cnt_r;
	sfc_last_e last_fault_r;
	logic [31:0] rdata_nxt;
	logic rd_err_nxt;

	// decoded controls
	logic reentry_block_on;
	logic fault_nmi_to_nonsecure;
	logic fp_context_secure;
	logic fp_clear_on_return;
	logic fp_clear_on_return_lock;

	// event strobes
	logic reentry_armed;
	logic reentry_hit;
	logic exec_never_hit;
	logic preempt_open;
	logic preempt_ev;
	logic fp_clear_hit;
	logic [SFC_EV_W-1:0] ev_set;
	logic [SFC_EV_W-1:0] status_clr;

	// bus strobes
	logic apb_setup;
	logic apb_access;
	logic apb_wr;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_status;
	logic wr_count;
	sfc_sel_e sel;

	// map a byte address onto a register select
	function automatic sfc_sel_e sfc_decode(input logic [11:0] addr);
		sfc_sel_e s;
		s = SFC_SEL_NONE;
		case (addr)
			SFC_OFS_CTRL: s = SFC_SEL_CTRL;
			SFC_OFS_STATE: s = SFC_SEL_STATE;
			SFC_OFS_INT_STATUS: s = SFC_SEL_INT_STATUS;
			SFC_OFS_INT_MASK: s = SFC_SEL_INT_MASK;
			SFC_OFS_FAULT_COUNT: s = SFC_SEL_FAULT_COUNT;
			default: s = SFC_SEL_NONE;
		endcase
		return s;
	endfunction : sfc_decode

	// saturating increment of a fault counter
	function automatic logic [CNT_W-1:0] sfc_sat_inc(input logic [CNT_W-1:0] v);
		logic [CNT_W-1:0] r;
		r = v;
		if (v != {CNT_W{1'b1}}) begin
			r = v + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		return r;
	endfunction : sfc_sat_inc

	// write strobe for one register select
	function automatic logic sfc_wr_hit(input logic wr, input sfc_sel_e s, input sfc_sel_e t);
		return wr && (s == t);
	endfunction : sfc_wr_hit

	// control fields
	assign reentry_block_on = ctrl_r[SFC_CTRL_THREAD_REENTRY_BLOCK];
	assign fault_nmi_to_nonsecure = ctrl_r[SFC_CTRL_FAULT_NMI_TO_NONSECURE];
	assign fp_context_secure = ctrl_r[SFC_CTRL_FP_CONTEXT_SECURE];
	assign fp_clear_on_return = ctrl_r[SFC_CTRL_FP_CLEAR_ON_RETURN];
	assign fp_clear_on_return_lock = ctrl_r[SFC_CTRL_FP_CLEAR_ON_RETURN_LOCK];

	// apb phases; the slave never waits
	assign apb_setup = psel & ~penable;
	assign apb_access = psel & penable;
	assign apb_wr = apb_access & pwrite & ~pslverr;
	assign sel = sfc_decode(paddr);
	assign pready = 1'b1;

	// write strobes, one per writable register
	assign wr_ctrl = sfc_wr_hit(apb_wr, sel, SFC_SEL_CTRL);
	assign wr_mask = sfc_wr_hit(apb_wr, sel, SFC_SEL_INT_MASK);
	assign wr_status = sfc_wr_hit(apb_wr, sel, SFC_SEL_INT_STATUS);
	assign wr_count = sfc_wr_hit(apb_wr, sel, SFC_SEL_FAULT_COUNT);

	// write-one-to-clear mask for the sticky status
	assign status_clr = {SFC_EV_W{wr_status}} & pwdata[SFC_EV_W-1:0];

	// reentry armed: block on, thread mode, frame on the current stack
	assign reentry_armed = reentry_block_on & thread_mode & exc_frame_present;
	// gateway reentry: only thread mode entries look at the stack frame
	assign reentry_hit = secure_gateway_instr & reentry_armed;

	// privileged fetch from exec-never memory
	assign exec_never_hit = fetch_valid & fetch_priv_exec_never & privileged;

	// preemption of secure code by nonsecure exceptions
	always_comb begin
		preempt_open = 1'b1;
		if (secure_context) begin
			// severe fault handler is never preempted from the nonsecure side
			preempt_open = fault_nmi_to_nonsecure & ns_exc_nmi_class
				& ~in_severe_fault_handler;
		end
	end
	assign ns_preempt_grant = ns_exc_req & preempt_open;
	// only a grant that interrupts secure code is logged
	assign preempt_ev = ns_preempt_grant & secure_context;

	// secure fp values are hidden while nonsecure code runs
	assign fp_ns_view_block = fp_context_secure & fp_owner_secure & ns_state;

	// fp clear on return; the lock copy covers returns out of secure code
	assign fp_clear_hit = exception_return_code & (fp_clear_on_return
		| (fp_clear_on_return_lock & return_from_secure));

	// event vector into the sticky status
	always_comb begin
		ev_set = SFC_EV_RST;
		ev_set[SFC_EV_INVALID_ENTRY] = reentry_hit;
		ev_set[SFC_EV_MEM_MANAGE] = exec_never_hit;
		ev_set[SFC_EV_NS_PREEMPT] = preempt_ev;
		ev_set[SFC_EV_FP_CLEAR] = fp_clear_hit;
	end

	// gateway commit, one cycle after the instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gateway_commit <= 1'b0;
		end else begin
			// a faulting entry never commits the state change
			gateway_commit <= secure_gateway_instr & ~reentry_hit;
		end
	end

	// invalid entry fault pulse, one cycle after the instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			invalid_entry_fault <= 1'b0;
		end else begin
			invalid_entry_fault <= reentry_hit;
		end
	end

	// exec-never fault pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			memory_management_fault <= 1'b0;
		end else begin
			memory_management_fault <= exec_never_hit;
		end
	end

	// fp context clear pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fp_context_clear <= 1'b0;
		end else begin
			fp_context_clear <= fp_clear_hit;
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= SFC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= pwdata[SFC_CTRL_W-1:0];
		end
	end

	// interrupt mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask_r <= SFC_EV_RST;
		end else if (wr_mask) begin
			int_mask_r <= pwdata[SFC_EV_W-1:0];
		end
	end

	// sticky status bits, write one to clear, a new event wins
	generate
		for (genvar i = 0; i < SFC_EV_W; i++) begin : g_status
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					int_status_r[i] <= 1'b0;
				end else if (ev_set[i]) begin
					int_status_r[i] <= 1'b1;
				end else if (status_clr[i]) begin
					int_status_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// level interrupt from unmasked status
	assign irq = |(int_status_r & int_mask_r);

	// invalid entry counter, cleared by any write to its register; clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_cnt_r <= CNT_W'(SFC_CNT_RST);
		end else if (wr_count) begin
			entry_cnt_r <= CNT_W'(SFC_CNT_RST);
		end else if (reentry_hit) begin
			entry_cnt_r <= sfc_sat_inc(entry_cnt_r);
		end
	end

	// exec-never counter, cleared together with the entry counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mm_cnt_r <= CNT_W'(SFC_CNT_RST);
		end else if (wr_count) begin
			mm_cnt_r <= CNT_W'(SFC_CNT_RST);
		end else if (exec_never_hit) begin
			mm_cnt_r <= sfc_sat_inc(mm_cnt_r);
		end
	end

	// most recent fault kind; entry fault takes priority on a tie
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_fault_r <= SFC_LAST_NONE;
		end else if (reentry_hit) begin
			last_fault_r <= SFC_LAST_INVALID_ENTRY;
		end else if (exec_never_hit) begin
			last_fault_r <= SFC_LAST_MEM_MANAGE;
		end
	end

	// read mux, evaluated in the setup phase
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		rd_err_nxt = 1'b0;
		case (sel)
			SFC_SEL_CTRL: begin
				rdata_nxt[SFC_CTRL_W-1:0] = ctrl_r;
			end
			SFC_SEL_STATE: begin
				rdata_nxt[SFC_ST_GATEWAY_BLOCKED] = reentry_armed;
				rdata_nxt[SFC_ST_FP_VIEW_BLOCKED] = fp_ns_view_block;
				rdata_nxt[SFC_ST_PREEMPT_OPEN] = preempt_open;
				rdata_nxt[SFC_ST_LAST_FAULT_HI:SFC_ST_LAST_FAULT_LO] = last_fault_r;
			end
			SFC_SEL_INT_STATUS: begin
				rdata_nxt[SFC_EV_W-1:0] = int_status_r;
			end
			SFC_SEL_INT_MASK: begin
				rdata_nxt[SFC_EV_W-1:0] = int_mask_r;
			end
			SFC_SEL_FAULT_COUNT: begin
				rdata_nxt[SFC_CNT_ENTRY_LO +: CNT_W] = entry_cnt_r;
				rdata_nxt[SFC_CNT_MM_LO +: CNT_W] = mm_cnt_r;
			end
			default: begin
				rd_err_nxt = 1'b1;
			end
		endcase
	end

	// read data captured at setup, held through the access; writes read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end
	end

	// error captured at setup, dropped once the slave is deselected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			pslverr <= rd_err_nxt;
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end

endmodule : sfc_secure_checks
